// file: core/ifsb_map.vh
// Register map, field positions, reset values for the interrupt flag status bank.
// Assumes an APB slave with 32-bit data; each 16-bit register sits in the low half of a word.
`ifndef IFSB_MAP_VH
`define IFSB_MAP_VH

// ============================================================
// Offsets
`define IFSB_OFS_FLAGS_ONE  12'h000
`define IFSB_OFS_FLAGS_TWO  12'h004

// ============================================================
// Field layout: implemented bits
`define IFSB_MASK_ONE       16'h005f
`define IFSB_MASK_TWO       16'h0200
`define IFSB_BIT_PIN_CHANGE 3
`define IFSB_BIT_CCT5       9

// ============================================================
// Reset values
`define IFSB_RST_ONE        16'h0000
`define IFSB_RST_TWO        16'h0000

`endif

// file: core/ifsb_flag_reg.v
// One 16-bit hardware-settable flag register with a mask of implemented bits.
// Assumes set pulses and write strobes arrive on i_clk.
`timescale 1ns/1ns
module ifsb_flag_reg
#(
    parameter [15:0] MASK    = 16'hffff,
    parameter [15:0] RST_VAL = 16'h0000
)
(
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_srst,
    input  wire        i_ce,
    // Hardware set pulses
    input  wire [15:0] i_set,
    // Software write
    input  wire        i_wr,
    input  wire [15:0] i_wdata,
    // State
    output wire [15:0] o_flags
);

reg  [15:0] flags_q;
wire [15:0] flags_d;

// The set term is ORed after the write so an event is never lost to a clear.
assign flags_d = ((i_wr ? i_wdata : flags_q) | i_set) & MASK;

always @(posedge i_clk)
begin
    if (i_srst)
        flags_q <= RST_VAL & MASK;
    else if (i_ce)
        flags_q <= flags_d;
end

assign o_flags = flags_q;

endmodule

// file: core/ifsb_top.v
// Interrupt flag status bank: two flag registers behind an APB slave.
// Assumes peripheral event pulses are synchronous to i_clk, one cycle wide.
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ns
`include "ifsb_map.vh"
module ifsb_top
(
    // Clock, reset, enable
    input  wire        i_clk,
    input  wire        i_srst,
    input  wire        i_ce,
    // APB slave
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [11:0] i_paddr,
    input  wire [31:0] i_pwdata,
    input  wire [3:0]  i_pstrb,
    output reg  [31:0] o_prdata,
    output reg         o_pready,
    output reg         o_pslverr,
    // Event pulses, first register bits 6,4,3,2,1,0
    input  wire        i_capcomp5_event,
    input  wire        i_ext_int1,
    input  wire        i_pin_change,
    input  wire        i_comparator,
    input  wire        i_bus_collision,
    input  wire        i_serial_event,
    // Event pulse, second register bit 9
    input  wire        i_capcomp5_timer,
    // Flag state
    output reg  [15:0] o_flags_one,
    output reg  [15:0] o_flags_two
);

// ============================================================
// Address decode
function [1:0] dec;
    input [11:0] a;
    begin
        case (a)
            `IFSB_OFS_FLAGS_ONE: dec = 2'h1;
            `IFSB_OFS_FLAGS_TWO: dec = 2'h2;
            default:             dec = 2'h0;
        endcase
    end
endfunction

// Slave answers one cycle into the access phase; pready is a register.
wire        access = i_psel & i_penable & ~o_pready;
wire [1:0]  hit    = dec(i_paddr);
// Only the low byte lanes carry the 16-bit register; both lanes must be enabled.
wire        lanes  = &i_pstrb[1:0];
wire        wr_one = access & i_pwrite & hit[0] & lanes;
wire        wr_two = access & i_pwrite & hit[1] & lanes;

// ============================================================
// Flag registers
wire [15:0] set_one;
wire [15:0] set_two;
wire [15:0] flags_one;
wire [15:0] flags_two;

assign set_one = {9'h000, i_capcomp5_event, 1'b0, i_ext_int1,
                  i_pin_change, i_comparator, i_bus_collision, i_serial_event};
assign set_two = {6'h00, i_capcomp5_timer, 9'h000};

ifsb_flag_reg #(.MASK(`IFSB_MASK_ONE), .RST_VAL(`IFSB_RST_ONE)) u_one
(
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_ce    (i_ce),
    .i_set   (set_one),
    .i_wr    (wr_one),
    .i_wdata (i_pwdata[15:0]),
    .o_flags (flags_one)
);

ifsb_flag_reg #(.MASK(`IFSB_MASK_TWO), .RST_VAL(`IFSB_RST_TWO)) u_two
(
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_ce    (i_ce),
    .i_set   (set_two),
    .i_wr    (wr_two),
    .i_wdata (i_pwdata[15:0]),
    .o_flags (flags_two)
);

// ============================================================
// Bus answer and registered state outputs
always @(posedge i_clk)
begin
    if (i_srst)
    begin
        o_prdata    <= 32'h00000000;
        o_pready    <= 1'b0;
        o_pslverr   <= 1'b0;
        o_flags_one <= 16'h0000;
        o_flags_two <= 16'h0000;
    end
    else if (i_ce)
    begin
        o_flags_one <= flags_one;
        o_flags_two <= flags_two;
        o_pready    <= access;
        o_pslverr   <= access & (hit == 2'h0);
        if (access & ~i_pwrite)
            o_prdata <= hit[0] ? {16'h0000, flags_one} :
                        hit[1] ? {16'h0000, flags_two} : 32'h00000000;
        else
            o_prdata <= 32'h00000000;
    end
end

endmodule

// file: verif/ifsb_checker.sv
// Concurrent checks on the ports of the interrupt flag status bank.
// Assumes the bench keeps i_ce high, so every edge counts.
`timescale 1ns/1ns
module ifsb_chk
(
    // Watched ports
    input wire        i_clk,
    input wire        i_srst,
    input wire [11:0] i_paddr,
    input wire        i_capcomp5_timer,
    input wire        i_pin_change,
    input wire [31:0] o_prdata,
    input wire        o_pready,
    input wire        o_pslverr,
    input wire [15:0] o_flags_one,
    input wire [15:0] o_flags_two
);
    // ============================================================
    // Properties
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    a_timer_set: assert property (i_capcomp5_timer |-> ##2 o_flags_two[9])
        else $error("timer flag not set");
    a_pin_set: assert property (i_pin_change |-> ##2 o_flags_one[3])
        else $error("pin change flag not set");
    a_clear_cause: assert property ($fell(o_flags_two[9]) |-> $past(o_pready))
        else $error("flag cleared without access");
    a_two_zero: assert property ((o_flags_two & 16'hfdff) == 16'h0000)
        else $error("unused flag bits set");
    a_rd_two: assert property (o_pready && i_paddr == 12'h004 |-> o_prdata[31:10] == 22'h0
        && o_prdata[8:0] == 9'h0)
        else $error("unused read bits set");
    a_idle_data: assert property (!o_pready |-> o_prdata == 32'h0 && !o_pslverr)
        else $error("answer outside ready");
    cover property (o_pslverr);
    cover property ($fell(o_flags_two[9]));
    cover property (o_flags_one == 16'h005f);
endmodule
bind ifsb_top ifsb_chk u_chk (.*);

// file: verif/tb.sv
// Bench for the interrupt flag status bank, APB master tasks.
// Assumes i_ce and i_pstrb are tied active.
`timescale 1ns/1ns
module tb;
    logic i_clk = 0, i_srst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
    logic [11:0] i_paddr = 0;
    logic [31:0] i_pwdata = 0;
    logic [6:0]  ev = 0;
    logic [32:0] rd;
    wire  [31:0] prdata;
    wire         pready, pslverr;
    integer bad_count = 0, comparisons = 0;
    always #5 i_clk = ~i_clk;
    ifsb_top DUT (.i_clk(i_clk), .i_srst(i_srst), .i_ce(1'b1), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .i_pstrb(4'hf), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_capcomp5_event(ev[6]), .i_ext_int1(ev[5]), .i_pin_change(ev[4]),
        .i_comparator(ev[3]), .i_bus_collision(ev[2]), .i_serial_event(ev[1]),
        .i_capcomp5_timer(ev[0]), .o_flags_one(), .o_flags_two());
    // ============================================================
    // Tasks
    task final_report;
        if (bad_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Events pulse at the edge that takes the access.
    task apb(input w, input [11:0] a, input [15:0] d, input [6:0] e);
        integer n;
        @(posedge i_clk);
        i_psel <= 1; i_pwrite <= w; i_paddr <= a; i_pwdata <= {16'h0, d};
        @(posedge i_clk);
        i_penable <= 1; ev <= e; n = 0;
        do begin @(posedge i_clk); ev <= 0; n++; end while (pready !== 1 && n < 20);
        if (n >= 20)
        begin
            bad_count++;
            final_report;
        end
        rd = {pslverr, prdata}; i_psel <= 0; i_penable <= 0;
    endtask
    task chk(input [32:0] x);
        comparisons++;
        if (rd !== x)
        begin
            bad_count++;
            $display("[ERR] %0t %h %h", $time, rd, x);
        end
    endtask
    task tr(input [11:0] wa, input [15:0] d, input [6:0] e, input [11:0] ra, input [32:0] x);
        apb(1, wa, d, e);
        apb(0, ra, 0, 0);
        chk(x);
    endtask
    // ============================================================
    // Sequence
    initial
    begin
        repeat (12) @(posedge i_clk);
        i_srst <= 0;
        apb(0, 12'h004, 0, 0); chk(0);
        tr(12'h000, 16'hffff, 0, 12'h000, 33'h5f);
        tr(12'h004, 16'hffff, 0, 12'h004, 33'h200);
        tr(12'h004, 0, 0, 12'h004, 0);
        tr(12'h000, 0, 0, 12'h000, 0);
        tr(12'h008, 0, 7'h10, 12'h000, 33'h8);
        apb(0, 12'h008, 0, 0); chk(33'h100000000);
        tr(12'h004, 0, 7'h01, 12'h004, 33'h200);
        tr(12'h008, 0, 7'h7f, 12'h000, 33'h5f);
        final_report;
    end
endmodule
